// ### include/fdpl_pkg.sv
`default_nettype none
package fdpl_pkg;
    // qualifying periods, own values, microseconds
    localparam int OC_QUALIFY_US   = 2;
    localparam int TEMP_QUALIFY_US = 10;
    localparam int CLK_MHZ         = 25;
    localparam int OC_QUALIFY_CYC  = OC_QUALIFY_US * CLK_MHZ;
    localparam int TEMP_QUALIFY_CYC = TEMP_QUALIFY_US * CLK_MHZ;
    localparam int QCNT_W          = 12;
    // non-overlap interval in ns and its cycle count (least time, round up)
    localparam int DEADTIME_MIN_NS = 10;
    localparam int DEADTIME_MAX_NS = 40;
    localparam int CLK_PERIOD_NS   = 40;
    localparam int DEADTIME_MIN_CYC = (DEADTIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEADTIME_MAX_CYC = DEADTIME_MAX_NS / CLK_PERIOD_NS;
    localparam logic [3:0] DEADTIME_RESET = 4'h1;
    localparam logic FAULT_RESET = 1'b0;

    typedef struct packed {
        logic highOn;
        logic lowOn;
    } fdpl_gate_s;

    typedef enum logic [1:0] {
        FDPL_BOTH_OFF = 2'b00,
        FDPL_HIGH_ON  = 2'b01,
        FDPL_GAP      = 2'b11,
        FDPL_LOW_ON   = 2'b10
    } fdpl_bridge_e;
endpackage
`default_nettype wire

// ### design/fdpl_bridge_gap.sv
`default_nettype none
module fdpl_bridge_gap
    import fdpl_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // control
    input  wire logic       wantHigh,
    input  wire logic       forceOff,
    input  wire logic [3:0] gapCycles,
    // gate drive
    output fdpl_gate_s      gate
);
    // ==========================================
    // state
    fdpl_bridge_e state, next_state;
    logic [3:0]   cnt, next_cnt;
    logic         target, next_target;
    logic [3:0]   gapEff;

    // clamp below one cycle, a zero gap would allow shoot-through
    assign gapEff = (gapCycles == 4'h0) ? 4'h1 : gapCycles;

    always_comb begin
        next_state  = state;
        next_cnt    = cnt;
        next_target = target;
        case (state)
            FDPL_BOTH_OFF: begin
                if (!forceOff) begin
                    next_target = wantHigh;
                    next_cnt    = gapEff;
                    next_state  = FDPL_GAP;
                end
            end
            FDPL_HIGH_ON, FDPL_LOW_ON: begin
                if (forceOff) begin
                    next_state = FDPL_BOTH_OFF;
                end else if (wantHigh != (state == FDPL_HIGH_ON)) begin
                    next_target = wantHigh;
                    next_cnt    = gapEff;
                    next_state  = FDPL_GAP;
                end
            end
            FDPL_GAP: begin
                if (forceOff) begin
                    next_state = FDPL_BOTH_OFF;
                end else if (cnt <= 4'h1) begin
                    next_state = target ? FDPL_HIGH_ON : FDPL_LOW_ON;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            default: next_state = FDPL_BOTH_OFF;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state  <= FDPL_BOTH_OFF;
            cnt    <= 4'h0;
            target <= 1'b0;
        end else begin
            state  <= next_state;
            cnt    <= next_cnt;
            target <= next_target;
        end
    end

    assign gate.highOn = (state == FDPL_HIGH_ON);
    assign gate.lowOn  = (state == FDPL_LOW_ON);

    a_gate_exclusive: assert property (@(posedge sys_clk) disable iff (!resetn)
        !(gate.highOn && gate.lowOn)) else $error("both gates on");
    a_gap_before_on: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(gate.highOn) |-> $past(state) == FDPL_GAP) else $error("high on without gap");
endmodule // fdpl_bridge_gap
`default_nettype wire

// ### design/fdpl_fault_latch.sv
`default_nettype none
module fdpl_fault_latch
    import fdpl_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // control pins
    input  wire logic       sleepIn,
    input  wire logic       muteIn,
    // comparator pins, high means fail
    input  wire logic       left_high_side_current_sense,
    input  wire logic       right_high_side_current_sense,
    input  wire logic       left_low_side_current_sense,
    input  wire logic       right_low_side_current_sense,
    input  wire logic       temp_sense_in,
    // modulator side
    input  wire logic       leftPwm,
    input  wire logic       rightPwm,
    input  wire logic [3:0] deadtimeCycles,
    output logic            modClkEn,
    // gate drives
    output fdpl_gate_s      leftGate,
    output fdpl_gate_s      rightGate,
    // status
    output logic            fault_flag_out
);
    // ==========================================
    // input synchronisers
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] rawIn, sync1, sync2;
    assign rawIn = {sleepIn, muteIn, temp_sense_in, right_low_side_current_sense,
                    left_low_side_current_sense, right_high_side_current_sense,
                    left_high_side_current_sense};

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= rawIn;
            sync2 <= sync1;
        end
    end

    logic sleepS, muteS, tempFail;
    logic [3:0] ocFail;
    assign ocFail   = sync2[3:0];
    assign tempFail = sync2[4];
    assign muteS    = sync2[5];
    assign sleepS   = sync2[6];

    // ==========================================
    // persistence counters, four current and one temperature
    logic [4:0] qualActive;
    logic [4:0] qualDone;
    assign qualActive[3:0] = ocFail & {4{!(sleepS || muteS)}};
    assign qualActive[4]   = tempFail && !sleepS;

    logic [QCNT_W-1:0] qcnt [5];
    logic [QCNT_W-1:0] next_qcnt [5];

    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_qual
            localparam logic [QCNT_W-1:0] LIMIT =
                QCNT_W'((g == 4) ? TEMP_QUALIFY_CYC : OC_QUALIFY_CYC);
            always_comb begin
                if (!qualActive[g]) begin
                    next_qcnt[g] = '0;
                end else if (qcnt[g] < LIMIT) begin
                    next_qcnt[g] = qcnt[g] + QCNT_W'(1);
                end else begin
                    next_qcnt[g] = qcnt[g];
                end
            end
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    qcnt[g] <= '0;
                end else begin
                    qcnt[g] <= next_qcnt[g];
                end
            end
            assign qualDone[g] = (qcnt[g] == LIMIT);
        end
    endgenerate

    // ==========================================
    // sticky fault latch
    logic next_fault;
    always_comb begin
        if (sleepS) begin
            next_fault = 1'b0;
        end else if (|qualDone) begin
            next_fault = 1'b1;
        end else begin
            next_fault = fault_flag_out;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            fault_flag_out <= FAULT_RESET;
        end else begin
            fault_flag_out <= next_fault;
        end
    end

    // ==========================================
    // gate drive, fault deliberately not a term here
    logic gatesOff;
    assign gatesOff = sleepS || muteS;
    assign modClkEn = !gatesOff;

    fdpl_bridge_gap u_left (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .wantHigh (leftPwm),
        .forceOff (gatesOff),
        .gapCycles(deadtimeCycles),
        .gate     (leftGate)
    );
    fdpl_bridge_gap u_right (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .wantHigh (rightPwm),
        .forceOff (gatesOff),
        .gapCycles(deadtimeCycles),
        .gate     (rightGate)
    );

    // ==========================================
    // checks
    sequence s_oc_hold;
        (ocFail[0] && !sleepS && !muteS) [*8];
    endsequence

    a_sleep_clears: assert property (@(posedge sys_clk) disable iff (!resetn)
        sleepS |=> !fault_flag_out) else $error("sleep did not clear fault");
    a_fault_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
        fault_flag_out && !sleepS |=> fault_flag_out) else $error("fault dropped");
    a_no_spurious: assert property (@(posedge sys_clk) disable iff (!resetn)
        !fault_flag_out && !(|qualDone) |=> !fault_flag_out) else $error("fault rose without cause");
    a_oc_counts: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_oc_hold |-> qcnt[0] >= QCNT_W'(7)) else $error("oc counter not counting");
    a_qual_restart: assert property (@(posedge sys_clk) disable iff (!resetn)
        !qualActive[2] |=> qcnt[2] == '0) else $error("counter not restarted");
    a_oc_sets: assert property (@(posedge sys_clk) disable iff (!resetn)
        qualDone[2] && !sleepS |=> fault_flag_out) else $error("low-side fault not latched");
    a_oc_suspend: assert property (@(posedge sys_clk) disable iff (!resetn)
        muteS |-> qualActive[3:0] == 4'h0) else $error("oc active in mute");
    a_temp_sleep: assert property (@(posedge sys_clk) disable iff (!resetn)
        sleepS |=> qcnt[4] == '0) else $error("temp active in sleep");
    a_temp_sets: assert property (@(posedge sys_clk) disable iff (!resetn)
        qualDone[4] && !sleepS |=> fault_flag_out) else $error("temp fault not latched");
    a_gates_off: assert property (@(posedge sys_clk) disable iff (!resetn)
        gatesOff |=> !leftGate.highOn && !leftGate.lowOn && !rightGate.highOn && !rightGate.lowOn)
        else $error("gate on in sleep or mute");
endmodule // fdpl_fault_latch
`default_nettype wire

// ### test/fdpl_host_model.sv
`default_nettype none
// ============================================================
// host side: drives sleep and mute, may react to the fault
// ============================================================
module fdpl_host_model
    import fdpl_pkg::*;
#(
    parameter int HOLD_CYC = 8
)(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // bench requests, mode 1 loops fault to mute, 2 pulses sleep
    input  wire logic [1:0] mode,
    input  wire logic       wantSleep,
    input  wire logic       wantMute,
    // device side
    input  wire logic       fault_flag_out,
    output logic            sleepIn,
    output logic            muteIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] holdCnt;

    // registered so sleep changes just after an edge
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            holdCnt <= 8'h00;
        end else if (mode == 2'h2 && fault_flag_out && holdCnt == 8'h00) begin
            holdCnt <= 8'(HOLD_CYC);
        end else if (holdCnt != 8'h00) begin
            holdCnt <= holdCnt - 8'h01;
        end
    end
    assign sleepIn = wantSleep | (holdCnt != 8'h00);
    assign muteIn  = wantMute | (mode == 2'h1 && fault_flag_out);
endmodule // fdpl_host_model
`default_nettype wire

// ### test/tb_top.sv
`default_nettype none
module tb_top
    import fdpl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int OC = OC_QUALIFY_CYC;
    localparam int TQ = TEMP_QUALIFY_CYC;
    typedef struct {
        logic [4:0] fail;
        int         hold;
        logic       expFault;
    } fdpl_row_s;
    // ============================================================
    // signals
    // ============================================================
    logic       sys_clk   = 1'b0;
    logic       resetn    = 1'b0;
    logic [1:0] mode      = 2'h0;
    logic       wantSleep = 1'b0;
    logic       wantMute  = 1'b0;
    logic       lPwm      = 1'b0;
    logic       rPwm      = 1'b1;
    logic [3:0] gapCyc    = 4'h3;
    logic [4:0] fail      = 5'h00;
    logic       sleepIn;
    logic       muteIn;
    logic       modClkEn;
    logic       fault_flag_out;
    fdpl_gate_s leftGate;
    fdpl_gate_s rightGate;
    int         n_errors    = 0;
    int         check_count = 0;
    fdpl_row_s  rows[10];

    always #20 sys_clk = ~sys_clk;
    fdpl_host_model #(.HOLD_CYC(8)) i_host (.sys_clk(sys_clk), .resetn(resetn), .mode(mode),
        .wantSleep(wantSleep), .wantMute(wantMute), .fault_flag_out(fault_flag_out),
        .sleepIn(sleepIn), .muteIn(muteIn));
    fdpl_fault_latch i_dut (.sys_clk(sys_clk), .resetn(resetn), .sleepIn(sleepIn), .muteIn(muteIn),
        .left_high_side_current_sense(fail[0]), .right_high_side_current_sense(fail[1]),
        .left_low_side_current_sense(fail[2]), .right_low_side_current_sense(fail[3]),
        .temp_sense_in(fail[4]), .leftPwm(lPwm), .rightPwm(rPwm), .deadtimeCycles(gapCyc),
        .modClkEn(modClkEn), .leftGate(leftGate), .rightGate(rightGate), .fault_flag_out(fault_flag_out));
    // ============================================================
    // tasks
    // ============================================================
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic check(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // sleep held past the two-flop sync so the clear surely lands
    task automatic clear;
        wantSleep = 1'b1;
        tick(4);
        wantSleep = 1'b0;
        tick(4);
    endtask
    task automatic pulse(input logic [4:0] f, input int n);
        fail = f;
        tick(n);
        fail = 5'h00;
        tick(3);
    endtask
    // ============================================================
    // sequence
    // ============================================================
    initial begin
        for (int i = 0; i < 5; i++) begin
            rows[2*i]   = '{5'(1 << i), (i == 4 ? TQ : OC) + 5, 1'b1};
            rows[2*i+1] = '{5'(1 << i), (i == 4 ? TQ : OC) - 5, 1'b0};
        end
        tick(4);
        resetn = 1'b1;
        check(fault_flag_out, 1'b0, "fault after reset");
        tick(2);
        foreach (rows[i]) begin
            clear();
            pulse(rows[i].fail, rows[i].hold);
            check(fault_flag_out, rows[i].expFault, "qualified fault");
        end
        clear();
        pulse(5'h01, OC + 5);
        lPwm = 1'b1;
        rPwm = 1'b0;
        tick(40);
        check(fault_flag_out, 1'b1, "fault sticky");
        check(leftGate.highOn, 1'b1, "gate kept under fault");
        lPwm = 1'b0;
        tick(1);
        check(leftGate.highOn | leftGate.lowOn, 1'b0, "gap starts");
        tick(1);
        check(leftGate.lowOn, 1'b0, "gap lasts");
        // gap of gapCyc cycles: low side off through the third edge, on at the fourth
        tick(1);
        check(leftGate.lowOn, 1'b0, "gap last cycle");
        tick(1);
        check(leftGate.lowOn, 1'b1, "complement on");
        tick(4);
        wantSleep = 1'b1;
        tick(3);
        check(fault_flag_out, 1'b0, "sleep clears fault");
        check(|{leftGate, rightGate}, 1'b0, "gates off in sleep");
        pulse(5'h10, TQ + 10);
        check(fault_flag_out, 1'b0, "sleep masks temperature");
        wantSleep = 1'b0;
        wantMute = 1'b1;
        tick(4);
        check(modClkEn, 1'b0, "clock stops in mute");
        check(|{leftGate, rightGate}, 1'b0, "gates off in mute");
        pulse(5'h0f, OC + 10);
        check(fault_flag_out, 1'b0, "mute masks overcurrent");
        pulse(5'h10, TQ + 5);
        check(fault_flag_out, 1'b1, "temperature under mute");
        wantMute = 1'b0;
        clear();
        // one passing cycle must throw away the count so far
        fail = 5'h08;
        tick(OC - 10);
        fail = 5'h00;
        tick(1);
        pulse(5'h08, OC - 10);
        check(fault_flag_out, 1'b0, "count restarts");
        mode = 2'h1;
        pulse(5'h04, OC + 5);
        check(muteIn & ~|{leftGate, rightGate}, 1'b1, "fault loops to mute");
        clear();
        mode = 2'h2;
        pulse(5'h02, OC + 5);
        tick(20);
        check(fault_flag_out, 1'b0, "automatic restart");
        check(modClkEn, 1'b1, "running after restart");
        mode = 2'h0;
        give_verdict();
    end
    initial begin
        tick(20000);
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
